// ---- src/spm_top.sv ----
// mode selection, 1+1 protection switching and port indicators with register access
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module spm_top #(
	parameter int unsigned ADDR_W = 8,
	parameter int unsigned BLINK_CYC = spm_pkg::BLINK_CYC,
	parameter int unsigned MDIX_CYC = spm_pkg::MDIX_CYC
) (
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	// mode straps, high is on
	input wire logic [5:0] mode_strap_in,
	// optical port status, bit 0 primary, bit 1 secondary
	input wire logic [1:0] opt_link_in,
	input wire logic [1:0] opt_module_fault_in,
	input wire logic [1:0] opt_oam_session_in,
	// copper port status, bit per port
	input wire logic [1:0] cu_link_in,
	input wire logic [1:0] cu_activity_in,
	input wire logic [1:0] cu_full_duplex_in,
	// axi4-lite write
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// fabric control
	output logic [15:0] fwd_map_out,
	output logic [1:0] cu_crossover_out,
	output logic low_speed_select_primary_out,
	output logic low_speed_select_secondary_out,
	// indicators
	output logic [1:0] fault_indicator_out,
	output logic [1:0] optical_link_indicator_out,
	output logic [1:0] active_indicator_out,
	output logic [1:0] oam_indicator_out,
	output logic [1:0] copper_link_activity_indicator_out,
	output logic [1:0] full_duplex_indicator_out,
	// console and interrupt
	output logic console_txd_out,
	output logic irq_out
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [3:0] ists;
		logic [3:0] imask;
		logic irq;
		spm_pkg::spm_mode_t mode;
		spm_pkg::spm_path_t path;
		logic [1:0] fault_prev;
		logic [15:0] fwd;
		logic [1:0] led_fault;
		logic [1:0] led_link;
		logic [1:0] led_active;
		logic [1:0] led_oam;
		logic [1:0] led_cu;
		logic [1:0] led_fdx;
		logic [1:0] mdix;
		logic lospd_pri;
		logic lospd_sec;
		logic [23:0] blink_cnt;
		logic blink_ph;
		logic [1:0] act_seen;
		logic [23:0] mdix_cnt;
		logic [7:0] lfsr;
		logic con_start;
		logic [7:0] con_data;
	} spm_state_t;

	spm_state_t s_q, s_d;
	spm_pkg::spm_mode_t mode_d;
	logic [1:0] opt_fault;
	logic [3:0] ev;
	logic con_busy;

	// strap priority: dual, then revertive, then non-revertive, else plain switch
	function automatic spm_pkg::spm_mode_t spm_decode_mode(input logic [5:0] st);
		if (st[spm_pkg::STRAP_DUAL]) begin
			return spm_pkg::SPM_MODE_DUAL;
		end else if (st[spm_pkg::STRAP_REV]) begin
			return spm_pkg::SPM_MODE_REV;
		end else if (st[spm_pkg::STRAP_NONREV]) begin
			return spm_pkg::SPM_MODE_NONREV;
		end
		return spm_pkg::SPM_MODE_SWITCH;
	endfunction : spm_decode_mode

	// allowed forwarding, bit src*4+dst
	function automatic logic [15:0] spm_fwd(input spm_pkg::spm_mode_t m, input spm_pkg::spm_path_t p);
		logic [15:0] f;
		int unsigned a;
		f = 16'h0000;
		a = (p == spm_pkg::SPM_PATH_PRIMARY) ? spm_pkg::P_PRI : spm_pkg::P_SEC;
		case (m)
			spm_pkg::SPM_MODE_SWITCH: begin
				for (int unsigned i = 0; i < spm_pkg::NPORT; i++) begin
					for (int unsigned j = 0; j < spm_pkg::NPORT; j++) begin
						f[i*4+j] = (i != j);
					end
				end
			end
			spm_pkg::SPM_MODE_DUAL: begin
				f[spm_pkg::P_PRI*4+spm_pkg::P_CU0] = 1'b1;
				f[spm_pkg::P_CU0*4+spm_pkg::P_PRI] = 1'b1;
				f[spm_pkg::P_SEC*4+spm_pkg::P_CU1] = 1'b1;
				f[spm_pkg::P_CU1*4+spm_pkg::P_SEC] = 1'b1;
			end
			spm_pkg::SPM_MODE_NONREV, spm_pkg::SPM_MODE_REV: begin
				f[a*4+spm_pkg::P_CU0] = 1'b1;
				f[spm_pkg::P_CU0*4+a] = 1'b1;
				f[a*4+spm_pkg::P_CU1] = 1'b1;
				f[spm_pkg::P_CU1*4+a] = 1'b1;
				f[spm_pkg::P_CU0*4+spm_pkg::P_CU1] = 1'b1;
				f[spm_pkg::P_CU1*4+spm_pkg::P_CU0] = 1'b1;
			end
			default: begin
				f = 16'h0000;
			end
		endcase
		return f;
	endfunction : spm_fwd

	// a protection port is faulty with no link or a module fault
	assign opt_fault = ~opt_link_in | opt_module_fault_in;
	assign mode_d = spm_decode_mode(mode_strap_in);

	// next state of the whole block
	always_comb begin
		s_d = s_q;
		ev = 4'h0;
		s_d.mode = mode_d;
		s_d.con_start = 1'b0;
		// protection path; outside protection the primary is nominal
		if (mode_d == spm_pkg::SPM_MODE_NONREV || mode_d == spm_pkg::SPM_MODE_REV) begin
			case (s_q.path)
				spm_pkg::SPM_PATH_PRIMARY: begin
					if (opt_fault[0] && !opt_fault[1]) begin
						s_d.path = spm_pkg::SPM_PATH_SECONDARY;
						ev[spm_pkg::IRQ_SWITCHOVER] = 1'b1;
					end
				end
				spm_pkg::SPM_PATH_SECONDARY: begin
					if (mode_d == spm_pkg::SPM_MODE_REV && !opt_fault[0]) begin
						s_d.path = spm_pkg::SPM_PATH_PRIMARY;
						ev[spm_pkg::IRQ_REVERT] = 1'b1;
					end else if (opt_fault[1]) begin
						s_d.path = spm_pkg::SPM_PATH_PRIMARY;
						ev[spm_pkg::IRQ_REVERT] = 1'b1;
					end
				end
				default: begin
					s_d.path = spm_pkg::SPM_PATH_PRIMARY;
				end
			endcase
		end else begin
			s_d.path = spm_pkg::SPM_PATH_PRIMARY;
		end
		s_d.fwd = spm_fwd(mode_d, s_d.path);
		ev[spm_pkg::IRQ_FAULT_PRI] = opt_fault[0] && !s_q.fault_prev[0];
		ev[spm_pkg::IRQ_FAULT_SEC] = opt_fault[1] && !s_q.fault_prev[1];
		s_d.fault_prev = opt_fault;
		// optical indicators
		s_d.led_fault = opt_fault;
		s_d.led_link = opt_link_in;
		s_d.led_oam = opt_oam_session_in;
		if (mode_d == spm_pkg::SPM_MODE_NONREV || mode_d == spm_pkg::SPM_MODE_REV) begin
			s_d.led_active[0] = opt_link_in[0] && s_d.path == spm_pkg::SPM_PATH_PRIMARY;
			s_d.led_active[1] = opt_link_in[1] && s_d.path == spm_pkg::SPM_PATH_SECONDARY;
		end else begin
			s_d.led_active = opt_link_in;
		end
		s_d.lospd_pri = mode_strap_in[spm_pkg::STRAP_LOSPD_PRI];
		s_d.lospd_sec = mode_strap_in[spm_pkg::STRAP_LOSPD_SEC];
		// blink window: activity seen so far in a half period blanks the indicator while blink_ph is high
		if (s_q.blink_cnt >= 24'(BLINK_CYC - 1)) begin
			s_d.blink_cnt = 24'h000000;
			s_d.blink_ph = !s_q.blink_ph;
			s_d.act_seen = cu_activity_in;
		end else begin
			s_d.blink_cnt = s_q.blink_cnt + 24'h000001;
			s_d.act_seen = s_q.act_seen | cu_activity_in;
		end
		s_d.led_cu = cu_link_in & ~(s_d.act_seen & {2{s_d.blink_ph}});
		s_d.led_fdx = cu_link_in & cu_full_duplex_in;
		// crossover hunt: pseudo-random flips while unlinked so two hunting ends meet
		if (s_q.mdix_cnt >= 24'(MDIX_CYC - 1)) begin
			s_d.mdix_cnt = 24'h000000;
			s_d.lfsr = {s_q.lfsr[6:0], s_q.lfsr[7] ^ s_q.lfsr[5] ^ s_q.lfsr[4] ^ s_q.lfsr[3]};
			s_d.mdix = s_q.mdix ^ (~cu_link_in & s_q.lfsr[1:0]);
		end else begin
			s_d.mdix_cnt = s_q.mdix_cnt + 24'h000001;
		end
		// write channel: address and data taken in either order
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_axi_awvalid && s_q.awready) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wready) begin
			s_d.w_got = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		if (s_d.aw_got && s_d.w_got && !s_d.bvalid) begin
			s_d.bvalid = 1'b1;
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bresp = spm_pkg::RESP_OKAY;
			case (s_d.awaddr[7:0])
				spm_pkg::REG_IRQ_MASK: begin
					if (s_d.wstrb[0]) begin
						s_d.imask = s_d.wdata[3:0];
					end
				end
				spm_pkg::REG_CONSOLE: begin
					// a byte written while the line is busy is dropped
					if (s_d.wstrb[0] && !con_busy && !s_q.con_start) begin
						s_d.con_start = 1'b1;
						s_d.con_data = s_d.wdata[7:0];
					end
				end
				spm_pkg::REG_STATUS, spm_pkg::REG_IRQ_STATUS: begin
					s_d.bresp = spm_pkg::RESP_OKAY; // read-only, write ignored
				end
				default: begin
					s_d.bresp = spm_pkg::RESP_SLVERR;
				end
			endcase
		end
		s_d.awready = !s_d.aw_got && !s_d.bvalid;
		s_d.wready = !s_d.w_got && !s_d.bvalid;
		// read channel; reading interrupt status clears it
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = spm_pkg::RESP_OKAY;
			s_d.rdata = 32'h00000000;
			case (s_axi_araddr[7:0])
				spm_pkg::REG_STATUS: begin
					s_d.rdata[10:0] = {con_busy, s_q.led_fault, s_q.led_link, s_q.path, s_q.mode};
				end
				spm_pkg::REG_IRQ_STATUS: begin
					s_d.rdata[3:0] = s_q.ists;
					s_d.ists = 4'h0;
				end
				spm_pkg::REG_IRQ_MASK: begin
					s_d.rdata[3:0] = s_q.imask;
				end
				spm_pkg::REG_CONSOLE: begin
					s_d.rdata[8] = con_busy || s_q.con_start;
				end
				default: begin
					s_d.rresp = spm_pkg::RESP_SLVERR;
				end
			endcase
		end
		s_d.arready = !s_d.rvalid;
		// set wins over the read clear
		s_d.ists = s_d.ists | ev;
		s_d.irq = |(s_d.ists & s_d.imask);
	end

	// state register; clock enable low freezes everything
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_q <= '0;
			s_q.mode <= spm_pkg::SPM_MODE_SWITCH;
			s_q.path <= spm_pkg::SPM_PATH_PRIMARY;
			s_q.imask <= spm_pkg::IRQ_MASK_RST;
			s_q.lfsr <= spm_pkg::LFSR_SEED;
			s_q.fault_prev <= 2'h3;
			s_q.fwd <= 16'h7BDE;
			s_q.awready <= 1'b1;
			s_q.wready <= 1'b1;
			s_q.arready <= 1'b1;
		end else if (ce_in) begin
			s_q <= s_d;
		end
	end

	// console line
	spm_console_tx u_console (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.ce_in(ce_in),
		.start_in(s_q.con_start),
		.data_in(s_q.con_data),
		.txd_out(console_txd_out),
		.busy_out(con_busy)
	);

	// outputs straight from the state register
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign fwd_map_out = s_q.fwd;
	assign cu_crossover_out = s_q.mdix;
	assign low_speed_select_primary_out = s_q.lospd_pri;
	assign low_speed_select_secondary_out = s_q.lospd_sec;
	assign fault_indicator_out = s_q.led_fault;
	assign optical_link_indicator_out = s_q.led_link;
	assign active_indicator_out = s_q.led_active;
	assign oam_indicator_out = s_q.led_oam;
	assign copper_link_activity_indicator_out = s_q.led_cu;
	assign full_duplex_indicator_out = s_q.led_fdx;
	assign irq_out = s_q.irq;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	a_switch_all_ports: assert property (s_q.mode == spm_pkg::SPM_MODE_SWITCH |-> fwd_map_out == 16'h7BDE)
		else $error("switch mode does not join all ports");
	a_dual_no_cross: assert property (s_q.mode == spm_pkg::SPM_MODE_DUAL |-> fwd_map_out == 16'h2184)
		else $error("dual mode forwards between pairs");
	a_standby_isolated: assert property ((s_q.mode == spm_pkg::SPM_MODE_REV || s_q.mode == spm_pkg::SPM_MODE_NONREV)
		&& s_q.path == spm_pkg::SPM_PATH_PRIMARY |-> fwd_map_out == 16'h590C)
		else $error("standby optical port carries traffic");
	a_switchover_move: assert property (ce_in && (mode_d == spm_pkg::SPM_MODE_REV || mode_d == spm_pkg::SPM_MODE_NONREV)
		&& s_q.path == spm_pkg::SPM_PATH_PRIMARY && opt_fault[0] && !opt_fault[1]
		|=> s_q.path == spm_pkg::SPM_PATH_SECONDARY && s_q.ists[spm_pkg::IRQ_SWITCHOVER])
		else $error("no switchover on primary fault");
	a_nonrev_hold: assert property (ce_in && mode_d == spm_pkg::SPM_MODE_NONREV
		&& s_q.path == spm_pkg::SPM_PATH_SECONDARY && !opt_fault[1] |=> s_q.path == spm_pkg::SPM_PATH_SECONDARY)
		else $error("non-revertive path left healthy secondary");
	a_revert_back: assert property (ce_in && mode_d == spm_pkg::SPM_MODE_REV
		&& s_q.path == spm_pkg::SPM_PATH_SECONDARY && !opt_fault[0] |=> s_q.path == spm_pkg::SPM_PATH_PRIMARY)
		else $error("revertive path did not return");
	a_copper_joined: assert property (s_q.mode != spm_pkg::SPM_MODE_DUAL |-> fwd_map_out[11] && fwd_map_out[14])
		else $error("copper ports cut apart");
	a_strap_priority: assert property (ce_in && mode_strap_in[0] |=> s_q.mode == spm_pkg::SPM_MODE_DUAL)
		else $error("dual strap did not take priority");
	a_fault_link_leds: assert property (ce_in |=> fault_indicator_out == $past(~opt_link_in | opt_module_fault_in)
		&& optical_link_indicator_out == $past(opt_link_in))
		else $error("optical fault or link indicator wrong");
	a_oam_led: assert property (ce_in |=> oam_indicator_out == $past(opt_oam_session_in))
		else $error("oam indicator wrong");
	a_standby_dark: assert property (s_q.path == spm_pkg::SPM_PATH_PRIMARY && s_q.mode[3:2] != 2'b00
		|-> !active_indicator_out[1])
		else $error("standby port shows active");
	a_copper_leds: assert property (ce_in && !cu_link_in[0] |=> !copper_link_activity_indicator_out[0]
		&& !full_duplex_indicator_out[0])
		else $error("copper indicator lit without link");
	a_fdx_led: assert property (ce_in && cu_link_in[1] |=> full_duplex_indicator_out[1] == $past(cu_full_duplex_in[1]))
		else $error("duplex indicator wrong");
	a_mdix_hold: assert property (ce_in && cu_link_in[0] |=> $stable(cu_crossover_out[0]))
		else $error("pair mapping changed while linked");
	a_irq_level: assert property (irq_out == |(s_q.ists & s_q.imask))
		else $error("interrupt level disagrees with status and mask");

	c_switchover: cover property (s_q.path == spm_pkg::SPM_PATH_PRIMARY ##1 s_q.path == spm_pkg::SPM_PATH_SECONDARY);
	c_revert: cover property (s_q.mode == spm_pkg::SPM_MODE_REV && s_q.path == spm_pkg::SPM_PATH_SECONDARY
		##1 s_q.path == spm_pkg::SPM_PATH_PRIMARY);
	c_dual_mode: cover property (s_q.mode == spm_pkg::SPM_MODE_DUAL);
	c_irq_raised: cover property (!irq_out ##1 irq_out);
endmodule : spm_top
`default_nettype wire

// ---- src/spm_pkg.sv ----
// shared constants and types for the protection-mode and indicator block
package spm_pkg;
	// clock and console timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CONSOLE_BAUD = 38_400;
	localparam int unsigned BAUD_DIV = CLK_HZ / CONSOLE_BAUD;
	localparam int unsigned CONSOLE_DATA_BITS = 8;
	localparam int unsigned CONSOLE_STOP_BITS = 1;
	localparam int unsigned CONSOLE_FRAME_SHIFTS = CONSOLE_DATA_BITS + CONSOLE_STOP_BITS;
	// indicator blink and crossover hunt slots
	localparam int unsigned BLINK_HALF_MS = 50;
	localparam int unsigned BLINK_CYC = BLINK_HALF_MS * 1_000_000 / CLK_PERIOD_NS;
	localparam int unsigned MDIX_SLOT_MS = 60;
	localparam int unsigned MDIX_CYC = MDIX_SLOT_MS * 1_000_000 / CLK_PERIOD_NS;
	// mode strap positions
	localparam int unsigned STRAP_DUAL = 0;
	localparam int unsigned STRAP_NONREV = 1;
	localparam int unsigned STRAP_REV = 2;
	localparam int unsigned STRAP_LOSPD_SEC = 3;
	localparam int unsigned STRAP_LOSPD_PRI = 4;
	localparam int unsigned STRAP_RSVD = 5;
	localparam int unsigned STRAP_W = 6;
	// port indexes in the forwarding map, bit = src*4+dst
	localparam int unsigned P_PRI = 0;
	localparam int unsigned P_SEC = 1;
	localparam int unsigned P_CU0 = 2;
	localparam int unsigned P_CU1 = 3;
	localparam int unsigned NPORT = 4;
	// register byte offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_MASK = 8'h08;
	localparam logic [7:0] REG_CONSOLE = 8'h0C;
	// interrupt status bits
	localparam int unsigned IRQ_SWITCHOVER = 0;
	localparam int unsigned IRQ_REVERT = 1;
	localparam int unsigned IRQ_FAULT_PRI = 2;
	localparam int unsigned IRQ_FAULT_SEC = 3;
	localparam int unsigned IRQ_W = 4;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;
	localparam logic [7:0] LFSR_SEED = 8'hA5;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// operating modes
	typedef enum logic [3:0] {
		SPM_MODE_SWITCH = 4'b0001,
		SPM_MODE_DUAL = 4'b0010,
		SPM_MODE_NONREV = 4'b0100,
		SPM_MODE_REV = 4'b1000
	} spm_mode_t;
	// which optical port carries traffic
	typedef enum logic [1:0] {
		SPM_PATH_PRIMARY = 2'b01,
		SPM_PATH_SECONDARY = 2'b10
	} spm_path_t;
endpackage : spm_pkg

// ---- src/spm_console_tx.sv ----
// serial console transmitter, 8 data bits, 1 stop bit, no parity
`timescale 1ns/1ps
`default_nettype none
module spm_console_tx (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	// byte request
	input wire logic start_in,
	input wire logic [7:0] data_in,
	// line and state
	output logic txd_out,
	output logic busy_out
);
	typedef struct packed {
		logic [11:0] cnt;
		logic [3:0] bitn;
		logic [8:0] sh;
		logic busy;
		logic txd;
	} spm_tx_state_t;

	spm_tx_state_t s_q, s_d;

	// start bit goes out at once, then data lsb first and the stop bit
	always_comb begin
		s_d = s_q;
		if (!s_q.busy) begin
			if (start_in) begin
				s_d.busy = 1'b1;
				s_d.txd = 1'b0;
				s_d.sh = {1'b1, data_in};
				s_d.bitn = 4'(spm_pkg::CONSOLE_FRAME_SHIFTS);
				s_d.cnt = 12'(spm_pkg::BAUD_DIV - 1);
			end
		end else if (s_q.cnt != 12'h000) begin
			s_d.cnt = s_q.cnt - 12'h001;
		end else if (s_q.bitn == 4'h0) begin
			s_d.busy = 1'b0; // stop bit has had its full time
		end else begin
			s_d.txd = s_q.sh[0];
			s_d.sh = {1'b1, s_q.sh[8:1]};
			s_d.bitn = s_q.bitn - 4'h1;
			s_d.cnt = 12'(spm_pkg::BAUD_DIV - 1);
		end
	end

	// idle line is high
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s_q <= '{cnt: 12'h000, bitn: 4'h0, sh: 9'h1FF, busy: 1'b0, txd: 1'b1};
		end else if (ce_in) begin
			s_q <= s_d;
		end
	end

	assign txd_out = s_q.txd;
	assign busy_out = s_q.busy;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	a_start_bit_low: assert property (ce_in && start_in && !s_q.busy |=> !txd_out && busy_out)
		else $error("console start bit not driven low");
	a_idle_line_high: assert property (!busy_out |-> txd_out)
		else $error("console line low while idle");
endmodule : spm_console_tx
`default_nettype wire

// ---- testbench/spm_link_partner.sv ----
// remote link partner: optical line status source and console terminal
`timescale 1ns/1ps
`default_nettype none
module spm_link_partner (
	// clock
	input wire logic clk_in,
	// requested line state
	input wire logic [1:0] link_req_in,
	input wire logic [1:0] fault_req_in,
	input wire logic [1:0] oam_req_in,
	// console line from the block
	input wire logic rxd_in,
	// optical status seen by the block
	output logic [1:0] opt_link_out,
	output logic [1:0] opt_fault_out,
	output logic [1:0] opt_oam_out,
	// received console byte
	output logic [7:0] rx_byte_out,
	output logic rx_done_out
);
	// line state changes only just after an edge, like a real module pin
	always_ff @(posedge clk_in) begin
		opt_link_out <= link_req_in;
		opt_fault_out <= fault_req_in;
		opt_oam_out <= oam_req_in;
	end
	// terminal at 38.4K, 8 data lsb first, 1 stop, no parity; done only if stop is high
	initial begin
		rx_done_out = 1'b0;
		rx_byte_out = 8'h00;
		forever begin
			@(negedge rxd_in);
			repeat (spm_pkg::BAUD_DIV / 2) @(posedge clk_in);
			for (int i = 0; i < 8; i++) begin
				repeat (spm_pkg::BAUD_DIV) @(posedge clk_in);
				rx_byte_out[i] = rxd_in;
			end
			repeat (spm_pkg::BAUD_DIV) @(posedge clk_in);
			rx_done_out = rxd_in;
		end
	end
endmodule : spm_link_partner
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the protection-mode and indicator block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_in = 1'b0, resetn_in = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic awr, wr, bv, arr, rv, txd, irq, lsp, lss;
	logic [5:0] strap = 6'h00;
	logic [1:0] lreq = 2'h3, freq = 2'h0, oreq = 2'h0, cl = 2'h0, ca = 2'h0, cf = 2'h0;
	logic [1:0] ol, of, oo, bresp, rresp, xo, fi, li, ai, oi, ci, di, r;
	logic [7:0] awa = 8'h00, ara = 8'h00, rxb;
	logic [31:0] wd = 32'h0, rd, d;
	logic [15:0] fm;
	logic rxok;
	int error_cnt = 0, tests_run = 0, n;
	logic [29:0] rows [12] = '{{6'h00, 2'h3, 2'h0, 2'h1, 16'h7BDE, 2'h3}, {6'h01, 2'h3, 2'h0, 2'h2, 16'h2184, 2'h3},
		{6'h02, 2'h3, 2'h0, 2'h3, 16'h590C, 2'h1}, {6'h02, 2'h3, 2'h1, 2'h0, 16'h6AC0, 2'h2},
		{6'h02, 2'h3, 2'h0, 2'h0, 16'h6AC0, 2'h2}, {6'h02, 2'h3, 2'h2, 2'h0, 16'h590C, 2'h1},
		{6'h04, 2'h3, 2'h1, 2'h0, 16'h6AC0, 2'h2}, {6'h04, 2'h3, 2'h0, 2'h0, 16'h590C, 2'h1},
		{6'h07, 2'h3, 2'h0, 2'h0, 16'h2184, 2'h3}, {6'h38, 2'h3, 2'h0, 2'h0, 16'h7BDE, 2'h3},
		{6'h06, 2'h2, 2'h0, 2'h0, 16'h6AC0, 2'h2}, {6'h06, 2'h3, 2'h0, 2'h0, 16'h590C, 2'h1}};
	// 100 MHz clock
	always #5 clk_in = ~clk_in;
	spm_top #(.BLINK_CYC(8), .MDIX_CYC(8)) spm_top_i (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(1'b1),
		.mode_strap_in(strap), .opt_link_in(ol), .opt_module_fault_in(of), .opt_oam_session_in(oo),
		.cu_link_in(cl), .cu_activity_in(ca), .cu_full_duplex_in(cf), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
		.fwd_map_out(fm), .cu_crossover_out(xo), .low_speed_select_primary_out(lsp),
		.low_speed_select_secondary_out(lss), .fault_indicator_out(fi), .optical_link_indicator_out(li),
		.active_indicator_out(ai), .oam_indicator_out(oi), .copper_link_activity_indicator_out(ci),
		.full_duplex_indicator_out(di), .console_txd_out(txd), .irq_out(irq));
	spm_link_partner spm_link_partner_i (.clk_in(clk_in), .link_req_in(lreq), .fault_req_in(freq),
		.oam_req_in(oreq), .rxd_in(txd), .opt_link_out(ol), .opt_fault_out(of), .opt_oam_out(oo),
		.rx_byte_out(rxb), .rx_done_out(rxok));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic tally_and_finish;
		if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// write and read hold each channel until its own ready, then wait for the answer
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge clk_in);
		awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= v; br <= 1'b1;
		do begin
			@(posedge clk_in);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (bv !== 1'b1);
		rs = bresp;
		br <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clk_in);
		arv <= 1'b1; ara <= a; rr <= 1'b1;
		do begin
			@(posedge clk_in);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		v = rd; rs = rresp;
		rr <= 1'b0;
	endtask : rd_reg
	// watchdog, well beyond the roughly 25k cycles the sequence needs
	initial begin
		#500_000;
		error_cnt++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		repeat (16) @(posedge clk_in);
		chk({fm, txd, irq, ai}, {16'h7BDE, 4'h8});
		resetn_in <= 1'b1;
		rd_reg(spm_pkg::REG_IRQ_MASK, d, r); chk(d, 32'h0);
		foreach (rows[k]) begin
			@(posedge clk_in);
			{strap, lreq, freq, oreq} <= rows[k][29:18];
			repeat (6) @(posedge clk_in);
			chk(fm, rows[k][17:2]);
			chk(fi, {~rows[k][23:22] | rows[k][21:20]});
			chk({li, oi}, {rows[k][23:22], rows[k][19:18]});
			chk({ai, lsp, lss}, {rows[k][1:0], rows[k][28:27]});
		end
		// interrupts: raise, read-clear, then masked
		wr_reg(spm_pkg::REG_IRQ_MASK, 32'hF, r);
		chk(r, spm_pkg::RESP_OKAY);
		rd_reg(spm_pkg::REG_IRQ_STATUS, d, r);
		repeat (2) @(posedge clk_in); chk(irq, 1'b0);
		rd_reg(spm_pkg::REG_STATUS, d, r); chk(d, 32'hD8);
		lreq <= 2'h2; repeat (6) @(posedge clk_in); chk(irq, 1'b1);
		rd_reg(spm_pkg::REG_IRQ_STATUS, d, r); chk(d, 32'h5); repeat (2) @(posedge clk_in); chk(irq, 1'b0);
		wr_reg(spm_pkg::REG_IRQ_MASK, 32'h0, r); lreq <= 2'h3; repeat (6) @(posedge clk_in); chk(irq, 1'b0);
		rd_reg(spm_pkg::REG_IRQ_STATUS, d, r); chk(d, 32'h2);
		// unmapped place
		rd_reg(8'h10, d, r);
		chk(d, 32'h0);
		chk(r, spm_pkg::RESP_SLVERR);
		wr_reg(8'h14, 32'h1, r); chk(r, spm_pkg::RESP_SLVERR);
		// unlinked copper keeps hunting; a nonzero lfsr cannot give ten empty slots in a row
		r = xo;
		n = 0;
		repeat (80) begin
			@(posedge clk_in);
			if (xo !== r) n++;
			r = xo;
		end
		chk(n != 0, 1'b1);
		// copper: duplex and steady link, then blink with activity
		cl <= 2'h3; cf <= 2'h1; repeat (40) @(posedge clk_in); chk({di, ci}, 4'h7);
		ca <= 2'h1; n = 0;
		r = xo;
		repeat (40) begin
			@(posedge clk_in);
			if (ci[0] === 1'b0) n++;
			chk(ci[1], 1'b1);
			chk(xo, r);
		end
		chk(n != 0, 1'b1);
		// console byte to the terminal
		wr_reg(spm_pkg::REG_CONSOLE, 32'hA6, r);
		n = 0;
		while (rxok !== 1'b1 && n < 30000) begin
			@(posedge clk_in);
			n++;
		end
		chk({rxok, rxb}, 9'h1A6);
		// second reset in mid-run: indicators dark, map back to plain switch, then protection resumes
		resetn_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		chk({fm, irq, ai, fi, li, oi}, {16'h7BDE, 9'h000});
		resetn_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		chk(fm, 16'h590C);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
